// File: rtl/sfp_core.sv
`timescale 1ns/100ps
// ============================================================================
// Synchronous FIFO with valid and ready on both sides.
module sfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 fill;
  } sfp_fifo_st_t;
  sfp_fifo_st_t st;
  sfp_fifo_st_t next_st;
  logic         push;
  logic         pop;

  // Full and empty come straight from the fill count.
  assign o_in_ready  = (st.fill != DEPTH[PW:0]);
  assign o_out_valid = (st.fill != '0);
  assign o_out_data  = st.mem[st.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and count update.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = i_in_data;
      next_st.wr         = PW'(st.wr + 1'b1);
    end
    if (pop) begin
      next_st.rd = PW'(st.rd + 1'b1);
    end
    next_st.fill = (PW+1)'(st.fill + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
  end

  // State register.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // sfp_fifo

// ============================================================================
// Serial flash pin interface: link logic on the serial clock, user side on
// the system clock.
module sfp_top (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_spi_clk,
  input  wire logic              i_cs_n,
  input  wire logic [3:0]        i_lane,
  output logic [3:0]             o_lane,
  output logic [3:0]             o_lane_oe,
  input  wire logic [1:0]        i_lane_mode,
  input  wire logic              i_four_lane_enable,
  input  wire logic              i_dir_out,
  input  wire logic [7:0]        i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  output logic [7:0]             o_rx_data,
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ready,
  output logic                   o_rx_overflow,
  output logic                   o_selected,
  output logic                   o_deselect,
  output logic [7:0]             o_page_index,
  output logic                   o_page_full,
  output logic                   o_write_guard_n,
  output logic                   o_pause_n,
  input  wire logic [1:0]        i_erase_kind,
  input  wire logic [20:0]       i_erase_addr,
  output logic [20:0]            o_erase_base
);
  // Lanes moved per serial clock edge for a lane mode.
  function automatic logic [2:0] lane_step(input sfp_pkg::sfp_lanes_t m);
    case (m)
      sfp_pkg::SFP_TWO:  lane_step = 3'h2;
      sfp_pkg::SFP_FOUR: lane_step = 3'h4;
      default:           lane_step = 3'h1;
    endcase
  endfunction

  // Quad is honoured only with four lane enable; else single lane.
  function automatic sfp_pkg::sfp_lanes_t eff_mode(input logic [1:0] m,
                                                  input logic       qe);
    if (m == 2'(sfp_pkg::SFP_FOUR) && !qe) begin
      eff_mode = sfp_pkg::SFP_ONE;
    end else if (m == 2'(sfp_pkg::SFP_TWO) || m == 2'(sfp_pkg::SFP_FOUR)) begin
      eff_mode = sfp_pkg::sfp_lanes_t'(m);
    end else begin
      eff_mode = sfp_pkg::SFP_ONE;
    end
  endfunction

  // Erase unit base address: sector, 32KB, 64KB block or whole array.
  function automatic logic [20:0] unit_base(input logic [1:0]  k,
                                            input logic [20:0] a);
    case (sfp_pkg::sfp_erase_t'(k))
      sfp_pkg::SFP_ERASE_SEC: unit_base = a & ~21'((1 << sfp_pkg::SECTOR_SHIFT) - 1);
      sfp_pkg::SFP_ERASE_B32: unit_base = a & ~21'((1 << sfp_pkg::BLK32_SHIFT) - 1);
      sfp_pkg::SFP_ERASE_B64: unit_base = a & ~21'((1 << sfp_pkg::BLK64_SHIFT) - 1);
      default:                unit_base = 21'h000000;
    endcase
  endfunction

  // ==========================================================================
  // Rising edge state of the link, cleared while chip select is high.
  typedef struct packed {
    logic [1:0] armed_s;
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] qe_s;
    logic [1:0] dir_s;
    logic [1:0] pause_s;
    logic [7:0] sr;
    logic [2:0] cnt;
    logic [7:0] rx_hold;
    logic       rx_tgl;
  } sfp_rise_t;
  // Falling edge state of the link, cleared while chip select is high.
  typedef struct packed {
    logic [1:0] req_s;
    logic       ack;
    logic [7:0] sr;
    logic [2:0] cnt;
  } sfp_fall_t;
  // System clock state.
  typedef struct packed {
    logic [1:0]                  cs_s;
    logic                        cs_last;
    logic [1:0]                  rx_s;
    logic                        rx_last;
    logic [1:0]                  ack_s;
    logic [1:0]                  guard_s;
    logic [1:0]                  hold_s;
    logic                        armed;
    logic                        req;
    logic [7:0]                  tx_word;
    logic                        ovf;
    logic                        desel;
    logic [7:0]                  page_idx;
    logic                        page_full;
    logic [20:0]                 erase_base;
  } sfp_sys_t;

  sfp_rise_t            rs;
  sfp_rise_t            next_rs;
  sfp_fall_t            fs;
  sfp_fall_t            next_fs;
  sfp_sys_t             ss;
  sfp_sys_t             next_ss;
  sfp_pkg::sfp_tx_state_t tx_st;
  sfp_pkg::sfp_tx_state_t next_tx_st;
  sfp_pkg::sfp_lanes_t  mode;
  logic [2:0]           step;
  logic                 pause_on;
  logic                 rx_event;
  logic                 fifo_ready;
  logic [3:0]           drive_mask;

  // Effective lane mode as seen by the link after its synchroniser.
  assign mode     = eff_mode(rs.mode_s2, rs.qe_s[1]);
  assign step     = lane_step(mode);
  // Pause works only while four lane enable is clear.
  assign pause_on = !rs.qe_s[1] && !rs.pause_s[1];

  // Input byte assembly on rising serial clock edges.
  always_comb begin
    next_rs         = rs;
    next_rs.armed_s = {rs.armed_s[0], ss.armed};
    next_rs.mode_s1 = i_lane_mode;
    next_rs.mode_s2 = rs.mode_s1;
    next_rs.qe_s    = {rs.qe_s[0], i_four_lane_enable};
    next_rs.dir_s   = {rs.dir_s[0], i_dir_out};
    next_rs.pause_s = {rs.pause_s[0], i_lane[3]};
    if (rs.armed_s[1] && !pause_on && !rs.dir_s[1]) begin
      case (mode)
        sfp_pkg::SFP_TWO:  next_rs.sr = {rs.sr[5:0], i_lane[1:0]};
        sfp_pkg::SFP_FOUR: next_rs.sr = {rs.sr[3:0], i_lane[3:0]};
        default:           next_rs.sr = {rs.sr[6:0], i_lane[0]};
      endcase
      next_rs.cnt = 3'(rs.cnt + step);
      if (next_rs.cnt == sfp_pkg::CNT_ZERO) begin
        next_rs.rx_hold = next_rs.sr;
        next_rs.rx_tgl  = !rs.rx_tgl;
      end
    end
  end

  // Chip select high clears the link state at once.
  always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end

  // Output shifting on falling serial clock edges; new word at byte start.
  always_comb begin
    next_fs       = fs;
    next_fs.req_s = {fs.req_s[0], ss.req};
    if (!fs.req_s[1]) begin
      next_fs.ack = 1'b0;
    end
    if (rs.dir_s[1] && !pause_on) begin
      if (fs.cnt == sfp_pkg::CNT_ZERO) begin
        if (fs.req_s[1] && !fs.ack) begin
          next_fs.sr  = ss.tx_word;
          next_fs.ack = 1'b1;
        end else begin
          next_fs.sr = sfp_pkg::FILL_BYTE;
        end
      end else begin
        next_fs.sr = 8'(fs.sr << step);
      end
      next_fs.cnt = 3'(fs.cnt + step);
    end
  end

  // Falling edge register; mode 0 and mode 3 differ only in idle level.
  always_ff @(negedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      fs <= '0;
    end else begin
      fs <= next_fs;
    end
  end

  // Lane drive: data from the falling edge register, enables gated at once.
  always_comb begin
    o_lane = 4'h0;
    case (mode)
      sfp_pkg::SFP_TWO: begin
        o_lane[1:0] = fs.sr[7:6];
        drive_mask  = 4'h3;
      end
      sfp_pkg::SFP_FOUR: begin
        o_lane     = fs.sr[7:4];
        drive_mask = 4'hF;
      end
      default: begin
        o_lane[1]  = fs.sr[7];
        drive_mask = 4'h2;
      end
    endcase
    if (i_cs_n || pause_on || !rs.dir_s[1]) begin
      o_lane_oe = 4'h0;
    end else begin
      o_lane_oe = drive_mask;
    end
  end

  // ==========================================================================
  // Received bytes queue for the user side.
  assign rx_event = ss.cs_s[1] == 1'b0 && ss.rx_s[1] != ss.rx_last;

  sfp_fifo #(
    .WIDTH (8),
    .DEPTH (sfp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (rx_event),
    .o_in_ready  (fifo_ready),
    .i_in_data   (rs.rx_hold),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_data)
  );

  // System side: synchronisers, transmit handshake and status.
  always_comb begin
    next_ss         = ss;
    next_tx_st      = tx_st;
    next_ss.cs_s    = {ss.cs_s[0], i_cs_n};
    next_ss.rx_s    = {ss.rx_s[0], rs.rx_tgl};
    next_ss.ack_s   = {ss.ack_s[0], fs.ack};
    next_ss.guard_s = {ss.guard_s[0], i_lane[2]};
    next_ss.hold_s  = {ss.hold_s[0], i_lane[3]};
    next_ss.desel   = 1'b0;
    next_ss.rx_last = ss.rx_s[1];
    if (ss.cs_s[1]) begin
      next_ss.armed = 1'b1;
    end
    next_ss.cs_last = ss.cs_s[1];
    // Chip select edges come from the second stage only; set events below win.
    if (!ss.cs_s[1] && ss.cs_last) begin
      next_ss.ovf       = 1'b0;
      next_ss.page_idx  = 8'h00;
      next_ss.page_full = 1'b0;
    end
    if (ss.cs_s[1] && !ss.cs_last) begin
      next_ss.desel = 1'b1;
    end
    if (rx_event) begin
      next_ss.page_idx = 8'(ss.page_idx + 1'b1);
      if (ss.page_idx == 8'(sfp_pkg::PAGE_BYTES - 1)) begin
        next_ss.page_full = 1'b1;
      end
      if (!fifo_ready) begin
        next_ss.ovf = 1'b1;
      end
    end
    next_ss.erase_base = unit_base(i_erase_kind, i_erase_addr);
    // Four phase word handshake toward the falling edge logic.
    case (tx_st)
      sfp_pkg::SFP_TX_IDLE: begin
        if (i_tx_valid) begin
          next_ss.tx_word = i_tx_data;
          next_ss.req     = 1'b1;
          next_tx_st      = sfp_pkg::SFP_TX_REQ;
        end
      end
      sfp_pkg::SFP_TX_REQ: begin
        if (ss.ack_s[1] || ss.cs_s[1]) begin
          next_ss.req = 1'b0;
          next_tx_st  = sfp_pkg::SFP_TX_DROP;
        end
      end
      sfp_pkg::SFP_TX_DROP: begin
        if (!ss.ack_s[1]) begin
          next_tx_st = sfp_pkg::SFP_TX_IDLE;
        end
      end
      default: begin
        next_tx_st = sfp_pkg::SFP_TX_IDLE;
      end
    endcase
  end

  // System state register.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ss         <= '0;
      ss.cs_s    <= 2'h3;
      ss.cs_last <= 1'b1;
      ss.guard_s <= 2'h3;
      ss.hold_s  <= 2'h3;
      tx_st      <= sfp_pkg::SFP_TX_IDLE;
    end else begin
      ss    <= next_ss;
      tx_st <= next_tx_st;
    end
  end

  // Status outputs; guard and pause read as inactive while lanes are reused.
  assign o_tx_ready      = (tx_st == sfp_pkg::SFP_TX_IDLE);
  assign o_rx_overflow   = ss.ovf;
  assign o_selected      = !ss.cs_s[1];
  assign o_deselect      = ss.desel;
  assign o_page_index    = ss.page_idx;
  assign o_page_full     = ss.page_full;
  assign o_write_guard_n = i_four_lane_enable | ss.guard_s[1];
  assign o_pause_n       = i_four_lane_enable | ss.hold_s[1];
  assign o_erase_base    = ss.erase_base;
endmodule // sfp_top

// File: rtl/sfp_pkg.sv
// What this block does
// - Chip select high deselects and floats every drivable data lane.
// - Chip select low selects; bits are taken and read data supplied.
// - No bits are taken before chip select has gone high then low; this block reads chip select as high at reset and arms even if it stays low.
// - Single lane: inbound bits are sampled on rising serial clock edges.
// - Single lane: outbound bits change on falling edges on lane one.
// - Dual and quad lanes are bidirectional: in on rise, out on fall.
// - Quad transfers run only while the four lane enable bit is set.
// - With four lane enable, guard and pause pins become lanes two, three.
// - Pause and restart pin functions exist only outside quad operation.
// - Single and dual use lanes zero and one; quad uses all four.
// - Array is 8192 pages of 256 bytes; one program writes 256 at most.
// - Erase covers 16, 128 or 256 pages, or the whole array.
// - There are 512 erasable sectors and 32 erasable 64KB blocks.
// - Serial clock up to 133MHz in every lane mode.
// - Internal erase, program or status write continues after deselect.
// - A 64-bit unique number and three 256-byte security registers exist.
// - Serial clock modes 0 and 3 are both supported.
// - Pause low while selected floats outputs and ignores clock and input.
package sfp_pkg;
  // ==========================================================================
  // Array geometry.
  localparam int unsigned PAGE_BYTES     = 256;
  localparam int unsigned PAGE_COUNT     = 8192;
  localparam int unsigned SECTOR_PAGES   = 16;
  localparam int unsigned BLK32_PAGES    = 128;
  localparam int unsigned BLK64_PAGES    = 256;
  localparam int unsigned SECTOR_COUNT   = 512;
  localparam int unsigned BLK64_COUNT    = 32;
  localparam int unsigned UNIQUE_ID_BITS = 64;
  localparam int unsigned SEC_REG_COUNT  = 3;
  localparam int unsigned SEC_REG_BYTES  = 256;
  localparam int unsigned ADDR_W         = 21;
  localparam int unsigned PAGE_SHIFT     = 8;
  localparam int unsigned SECTOR_SHIFT   = 12;
  localparam int unsigned BLK32_SHIFT    = 15;
  localparam int unsigned BLK64_SHIFT    = 16;
  // ==========================================================================
  // Link figures.
  localparam int unsigned SCLK_MAX_MHZ   = 133;
  localparam int unsigned SYS_CLK_MHZ    = 20;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam logic [7:0]  FILL_BYTE      = 8'hFF;
  localparam logic [2:0]  CNT_ZERO       = 3'h0;
  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {SFP_ONE, SFP_TWO, SFP_FOUR} sfp_lanes_t;
  typedef enum logic [1:0] {SFP_ERASE_SEC, SFP_ERASE_B32, SFP_ERASE_B64,
                            SFP_ERASE_ALL} sfp_erase_t;
  typedef enum {SFP_TX_IDLE, SFP_TX_REQ, SFP_TX_DROP} sfp_tx_state_t;
  typedef struct packed {
    logic [3:0] lane_in;
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
  } sfp_pins_t;
endpackage

// File: test/sfp_host.sv
`timescale 1ns/100ps
// ==========================================
// Host model: mode 0 clock, chip select, inbound lanes.
module sfp_host (
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_drv,
  input  wire logic [3:0] i_lane,
  input  wire logic [3:0] i_oe
);
  // Clock idles low and the device starts deselected.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_drv = 4'hF;
  end
  // One clock period; lanes are sampled at the rise.
  task automatic tick(output logic [3:0] smp);
    #62.5 o_sclk = 1'b1;
    smp = i_lane;
    #62.5 o_sclk = 1'b0;
  endtask
  // Selects, settles, moves n bytes at w lanes per edge, deselects.
  task automatic frame(input int w, input int n, input logic [7:0] first,
                       output logic [7:0] rd, output logic [3:0] oe_seen);
    logic [7:0] sh;
    logic [3:0] smp;
    o_cs_n = 1'b0;
    tick(smp);
    tick(smp);
    for (int b = 0; b < n; b++) begin
      sh = first + 8'(b);
      for (int e = 0; e < 8 / w; e++) begin
        if (w == 1) o_drv[0] = sh[7];
        else if (w == 2) o_drv[1:0] = sh[7:6];
        else o_drv = sh[7:4];
        sh = sh << w;
        tick(smp);
        rd = (w == 1) ? {rd[6:0], smp[1]} : (w == 2) ? {rd[5:0], smp[1:0]} : {rd[3:0], smp};
      end
    end
    oe_seen = i_oe;
    // Released lanes zero and one show the inverse of their last value; lanes two and three go high.
    #250 o_drv = {2'b11, ~o_drv[1:0]};
    o_cs_n = 1'b1;
    #250;
  endtask
endmodule // sfp_host

// File: test/sfp_properties.sv
`timescale 1ns/100ps
// ==========================================
// Port checker for the pin interface.
module sfp_properties (
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic        i_spi_clk,
  input wire logic        i_cs_n,
  input wire logic [3:0]  i_lane,
  input wire logic [3:0]  o_lane_oe,
  input wire logic        i_four_lane_enable,
  input wire logic        o_deselect,
  input wire logic [7:0]  o_page_index,
  input wire logic        o_page_full,
  input wire logic        o_write_guard_n,
  input wire logic        o_pause_n,
  input wire logic [1:0]  i_erase_kind,
  input wire logic [20:0] i_erase_addr,
  input wire logic [20:0] o_erase_base
);
  logic [20:0] exp_base;
  // Aligned erase base expected one cycle after the request.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) exp_base <= 21'h000000;
    else exp_base <= i_erase_addr & (i_erase_kind == 2'h0 ? 21'h1FF000 :
      i_erase_kind == 2'h1 ? 21'h1F8000 : i_erase_kind == 2'h2 ? 21'h1F0000 : 21'h000000);
  end
  a_cs_float:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_cs_n |-> o_lane_oe == 4'h0) else $error("Lanes driven while deselected.");
  a_lane_sets:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("Bad lane set.");
  a_quad_gate:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !i_four_lane_enable |-> o_lane_oe[3:2] == 2'h0) else $error("Quad without enable.");
  a_pins_lanes:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_four_lane_enable [*2] |-> o_write_guard_n && o_pause_n) else $error("Pin not freed.");
  a_desel_pulse:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_deselect |=> !o_deselect) else $error("Deselect pulse too long.");
  a_page_wrap:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $rose(o_page_full) |-> o_page_index == 8'h00) else $error("Page count off.");
  a_erase_base:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_erase_base == exp_base) else $error("Erase base misaligned.");
  a_pause_float:
    assert property (@(posedge i_spi_clk) disable iff (i_cs_n)
      (!i_four_lane_enable && !i_lane[3]) [*3] |-> o_lane_oe == 4'h0)
      else $error("Lanes driven in pause.");
endmodule // sfp_properties

bind sfp_top sfp_properties u_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_spi_clk(i_spi_clk), .i_cs_n(i_cs_n),
  .i_lane(i_lane), .o_lane_oe(o_lane_oe), .i_four_lane_enable(i_four_lane_enable),
  .o_deselect(o_deselect), .o_page_index(o_page_index), .o_page_full(o_page_full),
  .o_write_guard_n(o_write_guard_n), .o_pause_n(o_pause_n), .i_erase_kind(i_erase_kind),
  .i_erase_addr(i_erase_addr), .o_erase_base(o_erase_base));

// File: test/sfp_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
// ==========================================
// Bench for the pin interface.
module sfp_top_tb;
  logic        clk_sys, reset_n, four_en, dir_out, tx_valid, rx_ready;
  logic [1:0]  lane_mode, erase_kind;
  logic [20:0] erase_addr, erase_base;
  logic [7:0]  tx_data, rd, rx_data, page_index;
  logic        sclk, cs_n, tx_ready, rx_valid, rx_ovf, selected, deselect;
  logic        page_full, guard_n, pause_n;
  logic [3:0]  drv, lane_o, lane_oe, lane_w, oe_seen, smp;
  int          miscompares, checked, desel_cnt;
  // Wire level: the device wins where it drives.
  assign lane_w = (lane_oe & lane_o) | (~lane_oe & drv);
  // System clock, 50 ns.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Counts deselect pulses away from the edge that launches them.
  always @(negedge clk_sys) begin
    if (deselect === 1'b1) desel_cnt++;
  end
  sfp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_drv(drv), .i_lane(lane_w), .i_oe(lane_oe));
  sfp_top uut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_spi_clk(sclk), .i_cs_n(cs_n),
    .i_lane(lane_w), .o_lane(lane_o), .o_lane_oe(lane_oe), .i_lane_mode(lane_mode),
    .i_four_lane_enable(four_en), .i_dir_out(dir_out), .i_tx_data(tx_data),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .i_rx_ready(rx_ready), .o_rx_overflow(rx_ovf), .o_selected(selected),
    .o_deselect(deselect), .o_page_index(page_index), .o_page_full(page_full),
    .o_write_guard_n(guard_n), .o_pause_n(pause_n), .i_erase_kind(erase_kind),
    .i_erase_addr(erase_addr), .o_erase_base(erase_base));
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Waits a bounded time for a byte, compares it and pops it.
  task automatic pop(input logic [7:0] ex);
    int k;
    @(negedge clk_sys);
    for (k = 0; k < 200 && rx_valid !== 1'b1; k++) @(negedge clk_sys);
    if (k == 200) begin
      miscompares++;
      tally_and_finish();
    end
    `CHK("rx_data", ex, rx_data)
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
  endtask
  // Idle state after reset.
  task automatic t_idle();
    @(negedge clk_sys);
    `CHK("lane_oe", 4'h0, lane_oe)
    `CHK("selected", 1'b0, selected)
    `CHK("pause_n", 1'b1, pause_n)
    $display("idle done");
  endtask
  // Inbound byte per mode, quad without enable falling back to single.
  task automatic t_write();
    logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic       en [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int         wd [4] = '{1, 2, 4, 1};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      lane_mode = md[i];
      four_en = en[i];
      host.frame(wd[i], 1, 8'hA5 + 8'(i), rd, oe_seen);
      pop(8'hA5 + 8'(i));
    end
    $display("write done");
  endtask
  // Outbound word per mode: offered once the selection is seen, the first
  // byte out is fill and the second one carries the word.
  task automatic t_read();
    logic [3:0] oe_exp [3] = '{4'h2, 4'h3, 4'hF};
    int         wd [3] = '{1, 2, 4};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      dir_out = 1'b1;
      lane_mode = 2'(i);
      four_en = (i == 2);
      host.o_cs_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      tx_data = 8'h3C + 8'(i);
      tx_valid = 1'b1;
      @(negedge clk_sys);
      tx_valid = 1'b0;
      `CHK("tx ready busy", 1'b0, tx_ready)
      host.frame(wd[i], 2, 8'h00, rd, oe_seen);
      `CHK("read byte", 8'h3C + 8'(i), rd)
      `CHK("read lanes", oe_exp[i], oe_seen)
      `CHK("tx ready back", 1'b1, tx_ready)
    end
    @(negedge clk_sys);
    dir_out = 1'b0;
    four_en = 1'b0;
    lane_mode = 2'h0;
    $display("read done");
  endtask
  // Five bytes into the four deep buffer with nobody draining.
  task automatic t_fifo();
    int d0;
    d0 = desel_cnt;
    host.frame(1, 5, 8'h10, rd, oe_seen);
    @(negedge clk_sys);
    `CHK("deselect", d0 + 1, desel_cnt)
    `CHK("overflow", 1'b1, rx_ovf)
    `CHK("page index", 8'h05, page_index)
    for (int i = 0; i < 4; i++) pop(8'h10 + 8'(i));
    repeat (4) @(negedge clk_sys);
    `CHK("rx empty", 1'b0, rx_valid)
    $display("fifo done");
  endtask
  // A whole page in one selection.
  task automatic t_page();
    @(negedge clk_sys);
    rx_ready = 1'b1;
    host.frame(1, 256, 8'h00, rd, oe_seen);
    @(negedge clk_sys);
    rx_ready = 1'b0;
    `CHK("page full", 1'b1, page_full)
    `CHK("page wrap", 8'h00, page_index)
    $display("page done");
  endtask
  // Pause pin low floats the output, high resumes it.
  task automatic t_pause();
    @(negedge clk_sys);
    dir_out = 1'b1;
    host.o_drv[3] = 1'b0;
    host.o_cs_n = 1'b0;
    repeat (4) host.tick(smp);
    `CHK("paused", 4'h0, lane_oe)
    `CHK("pause pin", 1'b0, pause_n)
    host.o_drv[3] = 1'b1;
    repeat (4) host.tick(smp);
    `CHK("resumed", 4'h2, lane_oe)
    host.o_cs_n = 1'b1;
    #250;
    @(negedge clk_sys);
    dir_out = 1'b0;
    $display("pause done");
  endtask
  // Guard pin seen with four lane enable clear, freed with it set.
  task automatic t_guard();
    @(negedge clk_sys);
    host.o_drv[2] = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("guard", 1'b0, guard_n)
    four_en = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("guard freed", 1'b1, guard_n)
    four_en = 1'b0;
    host.o_drv[2] = 1'b1;
    $display("guard done");
  endtask
  // Erase base for every erase kind.
  task automatic t_erase();
    logic [20:0] ex [4] = '{21'h1AB000, 21'h1A8000, 21'h1A0000, 21'h000000};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      erase_kind = 2'(i);
      erase_addr = 21'h1ABCDE;
      @(negedge clk_sys);
      `CHK("erase base", ex[i], erase_base)
    end
    $display("erase done");
  endtask
  // Reset, then every scenario in turn.
  initial begin
    {reset_n, four_en, dir_out, tx_valid, rx_ready} = 5'h00;
    {lane_mode, erase_kind, erase_addr, tx_data} = 33'h000000000;
    miscompares = 0;
    checked = 0;
    desel_cnt = 0;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    t_idle();
    t_write();
    t_read();
    t_fifo();
    t_page();
    t_pause();
    t_guard();
    t_erase();
    tally_and_finish();
  end
  // Cuts a hang short.
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule // sfp_top_tb
